// ---- baau_byte_arith_add_unit.sv ----
// Byte arithmetic add unit: decimal, binary and complement add
`timescale 1ns/1ns
module baau_byte_arith_add_unit
(
	input  wire logic                          ref_clk,
	input  wire logic                          rst_n,
	input  wire logic                          start,
	input  wire logic [7:0]                    opcode,
	input  wire logic [baau_pkg::DATA_W-1:0]   operand_byte,
	input  wire logic [baau_pkg::DATA_W-1:0]   acc_load_data,
	input  wire logic                          acc_load,
	input  wire logic                          carry_load_data,
	input  wire logic                          carry_load,
	output logic                               busy,
	output logic                               done,
	output logic [baau_pkg::DATA_W-1:0]        main_operand_register,
	output logic                               carry_link_flag,
	output logic                               signed_range_flag
);
	import baau_pkg::*;

	baau_op_t         op_q;
	logic [7:0]       opnd_q;
	logic [CNT_W-1:0] cnt_q;
	logic             busy_q;
	logic             done_q;
	logic [7:0]       acc_q;
	logic             cy_q;
	logic             ov_q;

	// Decode only the upper five bits; low bits carry mode and pointer
	baau_op_t op_dec;
	always_comb
	begin
		op_dec = BAAU_NO_OP;
		if ((opcode & OPC_MASK) == OPC_BCD)
			op_dec = BAAU_BCD_SUM_OP;
		else if ((opcode & OPC_MASK) == OPC_BIN)
			op_dec = BAAU_BIN_SUM_OP;
		else if ((opcode & OPC_MASK) == OPC_INV)
			op_dec = BAAU_INVERTED_SUM_OP;
	end

	// Arithmetic results, all computed from captured operand
	logic [8:0] bin_sum;
	logic [8:0] inv_sum;
	logic [4:0] lo_raw;
	logic [4:0] hi_raw;
	logic [3:0] lo_dig;
	logic [3:0] hi_dig;
	logic       lo_cy;
	logic       hi_cy;
	always_comb
	begin
		// RL5 binary sum with carry
		bin_sum = {1'b0, acc_q} + {1'b0, opnd_q} + {8'h00, cy_q};
		// RL8 RL11 inverted operand sum
		inv_sum = {1'b0, acc_q} + {1'b0, ~opnd_q} + {8'h00, cy_q};
		// RL1 per digit decimal add
		lo_raw = {1'b0, acc_q[3:0]} + {1'b0, opnd_q[3:0]} + {4'h0, cy_q};
		lo_cy  = lo_raw > {1'b0, BCD_NINE};
		lo_dig = lo_cy ? 4'(lo_raw + {1'b0, BCD_ADJ}) : lo_raw[3:0];
		hi_raw = {1'b0, acc_q[7:4]} + {1'b0, opnd_q[7:4]} + {4'h0, lo_cy};
		hi_cy  = hi_raw > {1'b0, BCD_NINE};
		hi_dig = hi_cy ? 4'(hi_raw + {1'b0, BCD_ADJ}) : hi_raw[3:0];
	end

	// Cycle count per operation, in processor clocks
	logic [CNT_W-1:0] len_dec;
	always_comb
	begin
		case (op_dec)
			BAAU_BCD_SUM_OP: len_dec = CNT_W'(CYC_BCD);
			BAAU_BIN_SUM_OP: len_dec = CNT_W'(CYC_BIN);
			default:         len_dec = CNT_W'(CYC_INV);
		endcase
	end

	// RL12 operand captured at start
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			op_q   <= BAAU_NO_OP;
			opnd_q <= 8'h00;
		end
		else if (start && !busy_q && op_dec != BAAU_NO_OP)
		begin
			op_q   <= op_dec;
			opnd_q <= operand_byte;
		end
	end

	// Sequencer: counts down the microcycle length, ends with done
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			busy_q <= 1'b0;
			cnt_q  <= '0;
			done_q <= 1'b0;
		end
		else
		begin
			done_q <= 1'b0;
			if (!busy_q && start && op_dec != BAAU_NO_OP)
			begin
				busy_q <= 1'b1;
				cnt_q  <= CNT_W'(len_dec - CNT_W'(1));
			end
			else if (busy_q && cnt_q == CNT_W'(1))
			begin
				busy_q <= 1'b0;
				done_q <= 1'b1;
				cnt_q  <= '0;
			end
			else if (busy_q)
				cnt_q <= CNT_W'(cnt_q - CNT_W'(1));
		end
	end

	// Result writeback on the last microcycle; loads only while idle
	logic fin;
	assign fin = busy_q && cnt_q == CNT_W'(1);
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			acc_q <= ACC_RST;
			cy_q  <= 1'b0;
			ov_q  <= 1'b0;
		end
		else if (fin)
		begin
			case (op_q)
				BAAU_BCD_SUM_OP:
				begin
					// RL2 RL3 RL4 BCD writeback
					acc_q <= {hi_dig, lo_dig};
					cy_q  <= hi_cy;
				end
				BAAU_BIN_SUM_OP:
				begin
					// RL6 RL7 binary flags
					acc_q <= bin_sum[7:0];
					cy_q  <= bin_sum[8];
					ov_q  <= (acc_q[7] == opnd_q[7]) &&
						(bin_sum[7] != acc_q[7]);
				end
				BAAU_INVERTED_SUM_OP:
				begin
					// RL9 RL10 complement flags
					acc_q <= inv_sum[7:0];
					cy_q  <= inv_sum[8];
					ov_q  <= (inv_sum[7] == opnd_q[7]) &&
						(inv_sum[7] != acc_q[7]);
				end
				default:
				begin
					acc_q <= acc_q;
				end
			endcase
		end
		else if (!busy_q)
		begin
			if (acc_load)
				acc_q <= acc_load_data;
			if (carry_load)
				cy_q <= carry_load_data;
		end
	end

	assign busy                  = busy_q;
	assign done                  = done_q;
	assign main_operand_register = acc_q;
	assign carry_link_flag       = cy_q;
	assign signed_range_flag     = ov_q;

	// Assertions
	// RL1 decimal length
	property p_bcd_len;
		@(posedge ref_clk) disable iff (!rst_n)
		(start && !busy_q && op_dec == BAAU_BCD_SUM_OP) |-> ##23 done_q;
	endproperty
	a_bcd_len: assert property (p_bcd_len) else $error("bcd len"); // RL1

	property p_bin_len;
		@(posedge ref_clk) disable iff (!rst_n)
		(start && !busy_q && op_dec == BAAU_BIN_SUM_OP) |-> ##19 done_q;
	endproperty
	a_bin_len: assert property (p_bin_len) else $error("bin len"); // RL5

	property p_inv_len;
		@(posedge ref_clk) disable iff (!rst_n)
		(start && !busy_q && op_dec == BAAU_INVERTED_SUM_OP)
			|-> ##20 done_q;
	endproperty
	a_inv_len: assert property (p_inv_len) else $error("inv len"); // RL8

	property p_bcd_ov;
		@(posedge ref_clk) disable iff (!rst_n)
		(fin && op_q == BAAU_BCD_SUM_OP) |=> $stable(ov_q);
	endproperty
	a_bcd_ov: assert property (p_bcd_ov) else $error("bcd ov"); // RL4

	property p_bcd_valid;
		@(posedge ref_clk) disable iff (!rst_n)
		(fin && op_q == BAAU_BCD_SUM_OP && opnd_q[7:4] <= 4'h9 &&
			opnd_q[3:0] <= 4'h9 && acc_q[7:4] <= 4'h9 &&
			acc_q[3:0] <= 4'h9)
			|=> (acc_q[7:4] <= 4'h9 && acc_q[3:0] <= 4'h9);
	endproperty
	a_bcd_valid: assert property (p_bcd_valid) else $error("bcd"); // RL2

	property p_bin_cy;
		@(posedge ref_clk) disable iff (!rst_n)
		(fin && op_q == BAAU_BIN_SUM_OP) |=>
			{cy_q, acc_q} == 9'($past(acc_q)) + 9'($past(opnd_q))
			+ 9'($past(cy_q));
	endproperty
	a_bin_cy: assert property (p_bin_cy) else $error("bin cy"); // RL6

	property p_inv_sub;
		@(posedge ref_clk) disable iff (!rst_n)
		(fin && op_q == BAAU_INVERTED_SUM_OP && cy_q) |=>
			acc_q == 8'($past(acc_q) - $past(opnd_q));
	endproperty
	a_inv_sub: assert property (p_inv_sub) else $error("inv sub"); // RL11

	property p_inv_ov;
		@(posedge ref_clk) disable iff (!rst_n)
		(fin && op_q == BAAU_INVERTED_SUM_OP) |=>
			ov_q == (acc_q[7] == $past(opnd_q[7]) &&
			acc_q[7] != $past(acc_q[7]));
	endproperty
	a_inv_ov: assert property (p_inv_ov) else $error("inv ov"); // RL10

endmodule // baau_byte_arith_add_unit

// ---- baau_pkg.sv ----
// Package with constants for the byte arithmetic add unit
// What this block does
// RL1 - BCD add of accumulator, operand, carry; 23 cycles
// RL2 - BCD sum into accumulator, operand untouched
// RL3 - Carry set on upper decimal digit carry
// RL4 - BCD add keeps overflow flag unchanged
// RL5 - Binary add with carry, 19 cycles
// RL6 - Carry set on carry out of bit 7
// RL7 - Overflow when result sign differs both operands
// RL8 - Add inverted operand plus carry, 20 cycles
// RL9 - Carry set on carry out of top bit
// RL10 - Overflow: result sign equals operand, not accumulator
// RL11 - Carry set gives true twos complement subtract
// RL12 - Operand byte is fetched before arithmetic starts
package baau_pkg;
	localparam int          DATA_W       = 8;
	localparam int          CYC_BCD      = 23;
	localparam int          CYC_BIN      = 19;
	localparam int          CYC_INV      = 20;
	localparam int          CNT_W        = 5;
	localparam logic [7:0]  OPC_BCD      = 8'hE8;
	localparam logic [7:0]  OPC_BIN      = 8'hF0;
	localparam logic [7:0]  OPC_INV      = 8'hF8;
	localparam logic [7:0]  OPC_MASK     = 8'hF8;
	localparam logic [7:0]  ACC_RST      = 8'h00;
	localparam logic [3:0]  BCD_NINE     = 4'h9;
	localparam logic [3:0]  BCD_ADJ      = 4'h6;

	typedef enum logic [1:0] {
		BAAU_BCD_SUM_OP,
		BAAU_BIN_SUM_OP,
		BAAU_INVERTED_SUM_OP,
		BAAU_NO_OP
	} baau_op_t;
endpackage

// ---- baau_seq_model.sv ----
// Operand fetch model: memory read at pointer plus displacement
`timescale 1ns/1ns
module baau_seq_model
(
	input  wire logic       ref_clk,
	input  wire logic       wr_en,
	input  wire logic [7:0] wr_addr,
	input  wire logic [7:0] wr_data,
	input  wire logic [7:0] ptr_base,
	input  wire logic [7:0] disp,
	output logic      [7:0] operand_byte
);
	logic [7:0] mem_q [256];
	// Bench preloads; the unit never writes back
	always_ff @(posedge ref_clk)
		if (wr_en) mem_q[wr_addr] <= wr_data;
	assign operand_byte = mem_q[ptr_base + disp];
endmodule // baau_seq_model

// ---- baau_byte_arith_add_unit_tb.sv ----
// Self-checking bench for the byte arithmetic add unit
`timescale 1ns/1ns
module baau_byte_arith_add_unit_tb;
	import baau_pkg::*;
	logic       ref_clk, rst_n, start, busy, done, cy, ov, exp_ov;
	logic       acc_load, carry_load, carry_load_data, wr_en;
	logic [7:0] opcode, acc_load_data, opnd, acc, wr_addr, wr_data;
	logic [7:0] ptr_base, disp, a, m, opc;
	int         errors, compares, k;
	baau_seq_model baau_seq_model_inst (.ref_clk, .wr_en, .wr_addr,
		.wr_data, .ptr_base, .disp, .operand_byte(opnd));
	baau_byte_arith_add_unit baau_byte_arith_add_unit_inst (.ref_clk,
		.rst_n, .start, .opcode, .operand_byte(opnd), .acc_load_data,
		.acc_load, .carry_load_data, .carry_load, .busy, .done,
		.main_operand_register(acc), .carry_link_flag(cy),
		.signed_range_flag(ov));
	// 25 MHz clock
	initial
	begin
		ref_clk = 0;
		forever #20 ref_clk = ~ref_clk;
	end
	// Count one comparison, report a miss
	task automatic chk(logic [7:0] g, logic [7:0] x);
		compares++;
		if (g !== x)
			$display("MISMATCH %0t got %h exp %h", $time, g, x);
		errors += int'(g !== x);
	endtask
	// Expected {carry, overflow, accumulator}; decimal keeps overflow
	function automatic logic [9:0] exp_res(logic [7:0] o, x, y,
		logic c, v);
		logic [8:0] s;
		logic [4:0] lo, hi;
		s = o[7:3] == OPC_BIN[7:3] ? x + y + c : x + {1'b0, ~y} + c;
		lo = x[3:0] + y[3:0] + c;
		lo += lo > 9 ? 5'h6 : 5'h0;
		hi = x[7:4] + y[7:4] + lo[4];
		hi += hi > 9 ? 5'h6 : 5'h0;
		if (o[7:3] == OPC_BCD[7:3])
			return {hi[4], v, hi[3:0], lo[3:0]};
		return {s[8], (o[3] ? s[7] == y[7] : x[7] == y[7]) && s[7] != x[7],
			s[7:0]};
	endfunction
	// Preload, start, time the op; poke tries a start and load mid-op
	task automatic run(logic [7:0] o, x, y, logic c, logic poke);
		logic [9:0] e;
		logic [31:0] r;
		int n;
		e = exp_res(o, x, y, c, exp_ov);
		r = $urandom;
		@(posedge ref_clk);
		{wr_en, acc_load, carry_load, carry_load_data} <= {3'h7, c};
		{ptr_base, disp, wr_data, acc_load_data} <= {r[15:0], y, x};
		wr_addr <= r[15:8] + r[7:0];
		@(posedge ref_clk);
		{wr_en, acc_load, carry_load, start, opcode} <= {4'h1, o};
		@(posedge ref_clk);
		start <= 0;
		// Index n is the cycle number, the take edge ends cycle 1
		for (n = 2; n < 41; n++)
		begin
			@(posedge ref_clk);
			{start, acc_load, acc_load_data} <= {{2{poke && n == 3}}, ~x};
			#1;
			if (n == 2)
				chk(8'(busy), 8'h01);
			if (done === 1'b1)
				break;
		end
		chk(8'(n), 8'(!o[4] ? CYC_BCD : o[3] ? CYC_INV : CYC_BIN));
		chk(acc, e[7:0]);
		chk(8'(cy), 8'(e[9]));
		chk(8'(ov), 8'(e[8]));
		chk(opnd, y);
		exp_ov = e[8];
		// Done must drop after a single cycle
		@(posedge ref_clk);
		#1 chk(8'(done), 8'h00);
	endtask
	// Reset, corner cases, then random traffic
	initial
	begin
		{start, acc_load, carry_load, carry_load_data, wr_en, exp_ov} = 0;
		{opcode, acc_load_data, wr_addr, wr_data, ptr_base, disp} = 0;
		errors = 0;
		compares = 0;
		rst_n = 0;
		repeat (4) @(posedge ref_clk);
		chk(acc, ACC_RST);
		chk(8'({cy, ov, busy, done}), 8'h00);
		rst_n <= 1;
		void'($urandom(36));
		run(OPC_BCD, 8'h99, 8'h99, 1, 0);
		run(OPC_BCD | 8'h03, 8'h45, 8'h54, 0, 1);
		run(OPC_BIN, 8'h7F, 8'h01, 0, 0);
		run(OPC_BCD, 8'h00, 8'h00, 0, 0);
		run(OPC_BIN, 8'h80, 8'h80, 0, 1);
		run(OPC_INV, 8'h05, 8'h03, 1, 0);
		run(OPC_INV, 8'h05, 8'h03, 0, 0);
		run(OPC_INV, 8'h7F, 8'hFF, 1, 0);
		@(posedge ref_clk);
		{start, opcode} <= {1'b1, 8'hD0};
		@(posedge ref_clk);
		start <= 0;
		#1 chk(8'(busy), 8'h00);
		$display("corner tests done");
		for (k = 0; k < 30; k++)
		begin
			{a, m} = 16'($urandom);
			opc = 8'($urandom_range(2)) * 8'h08 + OPC_BCD;
			if (opc == OPC_BCD)
				{a, m} = {4'($urandom_range(9)), 4'($urandom_range(9)),
					4'($urandom_range(9)), 4'($urandom_range(9))};
			run(opc | 8'($urandom_range(7)), a, m, 1'($urandom), 1'(k));
		end
		$display("random tests done");
		close_out();
	end
	// Watchdog: runs take about 900 cycles
	initial
	begin
		#200000;
		errors++;
		close_out();
	end
	// Verdict and end of run
	task automatic close_out();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
endmodule // baau_byte_arith_add_unit_tb
